// >>> include/iexr_defs.svh
`ifndef IEXR_DEFS_SVH
`define IEXR_DEFS_SVH
// register byte offsets
`define IEXR_OFS_MSW        12'h000
`define IEXR_OFS_NC_ADDR    12'h004
`define IEXR_OFS_NC_STAT    12'h008
`define IEXR_OFS_CR_ADDR    12'h00c
`define IEXR_OFS_CR_STAT    12'h010
`define IEXR_OFS_MC_ADDR    12'h014
`define IEXR_OFS_MC_STAT    12'h018
`define IEXR_OFS_ESYN       12'h01c
`define IEXR_OFS_MCSYN      12'h020
`define IEXR_OFS_VPREFIX    12'h024
`define IEXR_OFS_DBGCTL     12'h028
`define IEXR_OFS_VOFS_BASE  12'h040
// status word fields, low word of 64-bit numbering (bit n -> 63-n)
`define IEXR_MSW_VUE        25
`define IEXR_MSW_WE         18
`define IEXR_MSW_CE         17
`define IEXR_MSW_EE         15
`define IEXR_MSW_PR         14
`define IEXR_MSW_FA         13
`define IEXR_MSW_ME         12
`define IEXR_MSW_FEM0       11
`define IEXR_MSW_DE         9
`define IEXR_MSW_FEM1       8
`define IEXR_MSW_IAS        5
`define IEXR_MSW_DAS        4
`define IEXR_DBG_RST_BIT    29
// vector address fields
`define IEXR_VPFX_MSB       31
`define IEXR_VPFX_LSB       16
`define IEXR_VOFS_MSB       15
`define IEXR_VOFS_LSB       4
`define IEXR_MSW_RESET      32'h0000_0000
`endif

// >>> include/iexr_pkg.sv
package iexr_pkg;
    typedef enum logic [1:0] {
        IEXR_RET_NC,
        IEXR_RET_CR,
        IEXR_RET_MC
    } iexr_ret_e;

    // per-type exception report from the pipeline
    typedef struct packed {
        logic [31:0] fault_addr;
        logic [31:0] next_addr;
        logic [31:0] forced_addr;
        logic        sel_next;
        logic        imprecise;
        logic        forced;
        logic        syn_valid;
        logic [31:0] syndrome;
    } iexr_exc_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } iexr_redirect_s;
endpackage : iexr_pkg

// >>> core/iexr_unit.sv
// Operation
// - critical interrupts save into critical pair, noncritical into noncritical pair
// - machine check is its own class, saved in machine-check pair
// - asynchronous interrupt saves address of next instruction
// - synchronous precise saves faulting or following address, per type and status
// - older instructions appear completed before a precise interrupt is taken
// - no younger instruction has executed when a precise interrupt is taken
// - imprecise saves faulting or later address; older done, younger not executed
// - context-sync forced imprecise interrupt saves forcing instruction address
// - execution-sync forcing instruction saved; barrier may save itself or next
// - system reset on core reset or debug control bit 34 write with debug enable
// - load class save address register with type-chosen instruction address
// - load syndrome or machine-check syndrome when the type uses it
// - copy whole status word into class save status register
// - every interrupt clears vector, wait, external, problem, float, space bits
// - critical interrupts clear critical and debug enable; noncritical keep them
// - machine check clears its enable; other defined bits stay unchanged
// - new status word governs first instruction fetched after the interrupt
// - vector is prefix high half, offset bits, four zero bits
// - taking an interrupt never clears a load-and-reserve reservation
// - each return restores status word and resumes at its saved address
// - syndrome update clears all other syndrome bits; other types leave it
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`include "iexr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module iexr_unit
    import iexr_pkg::*;
#(
    parameter int NUM_TYPES = 16
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [NUM_TYPES-1:0]    exc_pending,
    input  wire iexr_exc_s               exc_info [NUM_TYPES],
    input  wire logic                    pipe_quiesced,
    input  wire logic                    ret_req,
    input  wire iexr_ret_e               ret_kind,
    output logic [NUM_TYPES-1:0]         exc_ack,
    output logic                         ret_ack,
    output iexr_redirect_s               redirect,
    output logic [31:0]                  msw_out,
    output logic                         sys_reset_req
);
    if (NUM_TYPES < 16 || NUM_TYPES > 64) begin : g_bad_types
        $error("iexr_unit: NUM_TYPES must be 16..64");
    end

    typedef enum logic [1:0] {
        IEXR_BUS_IDLE,
        IEXR_BUS_ACCESS,
        IEXR_BUS_DONE
    } iexr_bus_e;

    localparam int TW = $clog2(NUM_TYPES);

    // fixed class of each type: 0 crit input, 12 watchdog, 15 debug are
    // critical-side, 1 machine check is its own; 0,4,10,11,12 are asynchronous
    function automatic logic is_crit(input logic [TW-1:0] t);
        return (t == TW'(0)) || (t == TW'(12)) || (t == TW'(15));
    endfunction : is_crit

    function automatic logic is_mchk(input logic [TW-1:0] t);
        return t == TW'(1);
    endfunction : is_mchk

    function automatic logic is_async(input logic [TW-1:0] t);
        return (t == TW'(0)) || (t == TW'(4)) || (t == TW'(10))
            || (t == TW'(11)) || (t == TW'(12));
    endfunction : is_async

    logic [31:0]  msw_reg;
    logic [31:0]  nc_addr_reg;
    logic [31:0]  nc_stat_reg;
    logic [31:0]  cr_addr_reg;
    logic [31:0]  cr_stat_reg;
    logic [31:0]  mc_addr_reg;
    logic [31:0]  mc_stat_reg;
    logic [31:0]  esyn_reg;
    logic [31:0]  mcsyn_reg;
    logic [31:0]  vprefix_reg;
    logic [31:0]  dbgctl_reg;
    logic [11:0]  vofs_reg [NUM_TYPES];
    iexr_bus_e    bus_state_reg;
    logic [11:0]  bus_addr_reg;
    logic         bus_write_reg;

    // masking by enable bits; async externals need external enable
    logic [NUM_TYPES-1:0] enabled;
    always_comb begin
        for (int i = 0; i < NUM_TYPES; i++) begin
            enabled[i] = exc_pending[i];
        end
        enabled[0]  = exc_pending[0]  && msw_reg[`IEXR_MSW_CE];
        enabled[1]  = exc_pending[1]  && msw_reg[`IEXR_MSW_ME];
        enabled[4]  = exc_pending[4]  && msw_reg[`IEXR_MSW_EE];
        enabled[10] = exc_pending[10] && msw_reg[`IEXR_MSW_EE];
        enabled[11] = exc_pending[11] && msw_reg[`IEXR_MSW_EE];
        enabled[12] = exc_pending[12] && msw_reg[`IEXR_MSW_CE];
        enabled[15] = exc_pending[15] && msw_reg[`IEXR_MSW_DE];
    end

    // lowest index wins; the rest stay pending at their sources
    logic          take;
    logic [TW-1:0] sel;
    always_comb begin
        take = 1'b0;
        sel  = '0;
        for (int i = NUM_TYPES - 1; i >= 0; i--) begin
            if (enabled[i]) begin
                take = 1'b1;
                sel  = TW'(i);
            end
        end
    end

    // interrupt is taken only at a clean boundary: older done, younger
    // squashed; the pipeline signals it and a redirect must not be in flight
    logic take_now;
    assign take_now = take && pipe_quiesced && !redirect.valid;

    iexr_exc_s cur;
    logic [31:0] save_addr;
    always_comb begin
        cur = exc_info[sel];
        if (is_async(sel)) begin
            save_addr = cur.next_addr;
        end else if (cur.imprecise) begin
            // forcing instruction (or barrier/next) supplied by the pipeline
            save_addr = cur.forced ? cur.forced_addr : cur.fault_addr;
        end else begin
            save_addr = cur.sel_next ? cur.next_addr : cur.fault_addr;
        end
    end

    logic [31:0] msw_next;
    always_comb begin
        msw_next = msw_reg;
        msw_next[`IEXR_MSW_VUE]  = 1'b0;
        msw_next[`IEXR_MSW_WE]   = 1'b0;
        msw_next[`IEXR_MSW_EE]   = 1'b0;
        msw_next[`IEXR_MSW_PR]   = 1'b0;
        msw_next[`IEXR_MSW_FA]   = 1'b0;
        msw_next[`IEXR_MSW_FEM0] = 1'b0;
        msw_next[`IEXR_MSW_FEM1] = 1'b0;
        msw_next[`IEXR_MSW_IAS]  = 1'b0;
        msw_next[`IEXR_MSW_DAS]  = 1'b0;
        if (is_crit(sel)) begin
            msw_next[`IEXR_MSW_CE] = 1'b0;
            msw_next[`IEXR_MSW_DE] = 1'b0;
        end
        if (is_mchk(sel)) begin
            msw_next[`IEXR_MSW_ME] = 1'b0;
        end
    end

    logic [31:0] vec_addr;
    assign vec_addr = {vprefix_reg[`IEXR_VPFX_MSB:`IEXR_VPFX_LSB],
                       vofs_reg[sel], 4'h0};

    logic [31:0] ret_addr;
    logic [31:0] ret_stat;
    always_comb begin
        case (ret_kind)
            IEXR_RET_CR: begin
                ret_addr = cr_addr_reg;
                ret_stat = cr_stat_reg;
            end
            IEXR_RET_MC: begin
                ret_addr = mc_addr_reg;
                ret_stat = mc_stat_reg;
            end
            default: begin
                ret_addr = nc_addr_reg;
                ret_stat = nc_stat_reg;
            end
        endcase
    end
    logic ret_now;
    assign ret_now = ret_req && !take_now && !redirect.valid;

    // bus: address phase, one wait cycle doing the access, then ready
    logic bus_go;
    logic wr_en;
    // ready is high again in the done cycle, so a pipelined address
    // phase sampled there must be accepted, not dropped
    assign bus_go = hsel && hready && htrans[1]
                 && bus_state_reg != IEXR_BUS_ACCESS;
    assign wr_en  = bus_state_reg == IEXR_BUS_ACCESS && bus_write_reg;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction : hit

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= IEXR_BUS_IDLE;
            bus_addr_reg  <= '0;
            bus_write_reg <= 1'b0;
            hreadyout     <= 1'b1;
        end else begin
            case (bus_state_reg)
                IEXR_BUS_IDLE, IEXR_BUS_DONE: begin
                    bus_state_reg <= IEXR_BUS_IDLE;
                    if (bus_go) begin
                        bus_state_reg <= IEXR_BUS_ACCESS;
                        bus_addr_reg  <= haddr[11:0];
                        bus_write_reg <= hwrite;
                        hreadyout     <= 1'b0;
                    end
                end
                IEXR_BUS_ACCESS: begin
                    bus_state_reg <= IEXR_BUS_DONE;
                    hreadyout     <= 1'b1;
                end
                default: begin
                    bus_state_reg <= IEXR_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(bus_addr_reg, `IEXR_OFS_MSW))     rd_mux = msw_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_NC_ADDR)) rd_mux = nc_addr_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_NC_STAT)) rd_mux = nc_stat_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_CR_ADDR)) rd_mux = cr_addr_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_CR_STAT)) rd_mux = cr_stat_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_MC_ADDR)) rd_mux = mc_addr_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_MC_STAT)) rd_mux = mc_stat_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_ESYN))    rd_mux = esyn_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_MCSYN))   rd_mux = mcsyn_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_VPREFIX)) rd_mux = vprefix_reg;
        if (hit(bus_addr_reg, `IEXR_OFS_DBGCTL))  rd_mux = dbgctl_reg;
        for (int i = 0; i < NUM_TYPES; i++) begin
            if (hit(bus_addr_reg, `IEXR_OFS_VOFS_BASE + 12'(4 * i))) begin
                rd_mux = {16'h0000, vofs_reg[i], 4'h0};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state_reg == IEXR_BUS_ACCESS && !bus_write_reg) begin
            hrdata <= rd_mux;
        end
    end

    // architected state; an interrupt or return in the same cycle
    // overrides a software write to the register it updates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msw_reg     <= `IEXR_MSW_RESET;
            nc_addr_reg <= '0;
            nc_stat_reg <= '0;
            cr_addr_reg <= '0;
            cr_stat_reg <= '0;
            mc_addr_reg <= '0;
            mc_stat_reg <= '0;
            esyn_reg    <= '0;
            mcsyn_reg   <= '0;
        end else begin
            if (wr_en) begin
                if (hit(bus_addr_reg, `IEXR_OFS_MSW))     msw_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_NC_ADDR)) nc_addr_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_NC_STAT)) nc_stat_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_CR_ADDR)) cr_addr_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_CR_STAT)) cr_stat_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_MC_ADDR)) mc_addr_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_MC_STAT)) mc_stat_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_ESYN))    esyn_reg <= hwdata;
                if (hit(bus_addr_reg, `IEXR_OFS_MCSYN))   mcsyn_reg <= hwdata;
            end
            if (take_now) begin
                msw_reg <= msw_next;
                if (is_mchk(sel)) begin
                    mc_addr_reg <= save_addr;
                    mc_stat_reg <= msw_reg;
                    mcsyn_reg   <= cur.syndrome;
                end else if (is_crit(sel)) begin
                    cr_addr_reg <= save_addr;
                    cr_stat_reg <= msw_reg;
                end else begin
                    nc_addr_reg <= save_addr;
                    nc_stat_reg <= msw_reg;
                end
                // whole-word load clears every other syndrome bit
                if (!is_mchk(sel) && cur.syn_valid) begin
                    esyn_reg <= cur.syndrome;
                end
                // no reservation port exists: reservations are untouched
            end else if (ret_now) begin
                msw_reg <= ret_stat;
            end
        end
    end

    // prefix and offsets reset to zero only to stay defined; software
    // must still load them before enabling any interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vprefix_reg <= '0;
            for (int i = 0; i < NUM_TYPES; i++) begin
                vofs_reg[i] <= '0;
            end
        end else if (wr_en) begin
            if (hit(bus_addr_reg, `IEXR_OFS_VPREFIX)) begin
                vprefix_reg <= {hwdata[`IEXR_VPFX_MSB:`IEXR_VPFX_LSB], 16'h0000};
            end
            for (int i = 0; i < NUM_TYPES; i++) begin
                if (hit(bus_addr_reg, `IEXR_OFS_VOFS_BASE + 12'(4 * i))) begin
                    vofs_reg[i] <= hwdata[`IEXR_VOFS_MSB:`IEXR_VOFS_LSB];
                end
            end
        end
    end

    // reset bit self-clears; the request is a one-cycle pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbgctl_reg    <= '0;
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= 1'b0;
            if (wr_en && hit(bus_addr_reg, `IEXR_OFS_DBGCTL)) begin
                dbgctl_reg <= hwdata & ~(32'h1 << `IEXR_DBG_RST_BIT);
                sys_reset_req <= hwdata[`IEXR_DBG_RST_BIT]
                              && msw_reg[`IEXR_MSW_DE];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            redirect <= '0;
            exc_ack  <= '0;
            ret_ack  <= 1'b0;
        end else begin
            redirect.valid <= take_now || ret_now;
            exc_ack        <= '0;
            ret_ack        <= ret_now;
            if (take_now) begin
                redirect.addr <= vec_addr;
                exc_ack       <= NUM_TYPES'(1) << sel;
            end else if (ret_now) begin
                redirect.addr <= ret_addr;
            end
        end
    end

    assign msw_out = msw_reg;

    property p_crit_pair;
        @(posedge hclk) disable iff (!hresetn)
        take_now && is_crit(sel) && !is_mchk(sel) |=>
            cr_stat_reg == $past(msw_reg) && nc_stat_reg == $past(nc_stat_reg);
    endproperty
    a_crit_pair: assert property (p_crit_pair) else $error("crit save wrong");

    property p_mchk_pair;
        @(posedge hclk) disable iff (!hresetn)
        take_now && is_mchk(sel) |=> mc_addr_reg == $past(save_addr)
            && !msw_reg[`IEXR_MSW_ME];
    endproperty
    a_mchk_pair: assert property (p_mchk_pair) else $error("mchk save wrong");

    property p_async_next;
        @(posedge hclk) disable iff (!hresetn)
        take_now && is_async(sel) |=> (is_crit($past(sel)) ? cr_addr_reg
            : nc_addr_reg) == $past(cur.next_addr);
    endproperty
    a_async_next: assert property (p_async_next) else $error("async addr");

    property p_quiesce;
        @(posedge hclk) disable iff (!hresetn)
        $rose(redirect.valid) && |exc_ack |-> $past(pipe_quiesced);
    endproperty
    a_quiesce: assert property (p_quiesce) else $error("taken unquiesced");

    property p_clear_bits;
        @(posedge hclk) disable iff (!hresetn)
        take_now |=> !msw_reg[`IEXR_MSW_EE] && !msw_reg[`IEXR_MSW_PR]
            && !msw_reg[`IEXR_MSW_IAS] && !msw_reg[`IEXR_MSW_DAS];
    endproperty
    a_clear_bits: assert property (p_clear_bits) else $error("msw not cleared");

    property p_noncrit_keep;
        @(posedge hclk) disable iff (!hresetn)
        take_now && !is_crit(sel) |=>
            msw_reg[`IEXR_MSW_DE] == $past(msw_reg[`IEXR_MSW_DE]);
    endproperty
    a_noncrit_keep: assert property (p_noncrit_keep) else $error("de changed");

    property p_vector;
        @(posedge hclk) disable iff (!hresetn)
        take_now |=> redirect.valid && redirect.addr[3:0] == 4'h0
            && redirect.addr[31:16] == vprefix_reg[31:16];
    endproperty
    a_vector: assert property (p_vector) else $error("vector wrong");

    property p_one_ack;
        @(posedge hclk) disable iff (!hresetn)
        $onehot0(exc_ack) and (|exc_ack |-> redirect.valid);
    endproperty
    a_one_ack: assert property (p_one_ack) else $error("multiple takes");

    property p_return;
        @(posedge hclk) disable iff (!hresetn)
        ret_now |=> ret_ack && msw_reg == $past(ret_stat)
            && redirect.addr == $past(ret_addr);
    endproperty
    a_return: assert property (p_return) else $error("return wrong");

    property p_sysrst;
        @(posedge hclk) disable iff (!hresetn)
        sys_reset_req |-> $past(msw_reg[`IEXR_MSW_DE]) && $past(wr_en);
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("bad sys reset");
endmodule : iexr_unit
`default_nettype wire

// >>> verification/iexr_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
module iexr_pipe_model #(
    parameter int N = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [N-1:0] raise,
    input  wire logic [N-1:0] exc_ack,
    output logic [N-1:0]      exc_pending,
    output logic              pipe_quiesced
);
    int seed = 32'hdc0d;
    // sources hold their level until taken, so losers stay visible
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_pending   <= '0;
            pipe_quiesced <= 1'b0;
        end else begin
            exc_pending   <= (exc_pending | raise) & ~exc_ack;
            // random stalls until older work is done
            pipe_quiesced <= ($random(seed) % 3) != 0;
        end
    end
endmodule : iexr_pipe_model
`default_nettype wire

// >>> verification/tb_interrupt_entry_return.sv
`include "iexr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_entry_return
    import iexr_pkg::*;
;
    localparam logic [31:0] ALL = (32'h1 << `IEXR_MSW_VUE)
        | (32'h1 << `IEXR_MSW_WE) | (32'h1 << `IEXR_MSW_EE)
        | (32'h1 << `IEXR_MSW_PR) | (32'h1 << `IEXR_MSW_FA)
        | (32'h1 << `IEXR_MSW_FEM0) | (32'h1 << `IEXR_MSW_FEM1)
        | (32'h1 << `IEXR_MSW_IAS) | (32'h1 << `IEXR_MSW_DAS);
    localparam logic [31:0] CR  = (32'h1 << `IEXR_MSW_CE)
        | (32'h1 << `IEXR_MSW_DE);
    localparam logic [31:0] MC  = 32'h1 << `IEXR_MSW_ME;
    localparam logic [31:0] DEF = ALL | CR | MC;
    logic           hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic           hwrite = 1'b0, ret_req = 1'b0;
    logic [31:0]    haddr = '0, hwdata = '0;
    logic [1:0]     htrans = '0;
    logic [2:0]     hsize = 3'h2;
    logic           hreadyout, hresp, pipe_quiesced, ret_ack;
    logic           sys_reset_req;
    logic [31:0]    hrdata, msw_out, rd, msw, esyn = '0, mcsyn = '0, vpfx;
    logic [31:0]    sa [3], ss [3], vofs [16];
    logic [15:0]    exc_pending, exc_ack, raise = '0;
    iexr_ret_e      ret_kind = IEXR_RET_NC;
    iexr_exc_s      info [16];
    iexr_exc_s      e;
    iexr_redirect_s redirect;
    int fails = 0, total_checks = 0, cyc = 0, nrst = 0, t;
    int seed = 32'hdc0d;
    int tl [10] = '{0, 1, 4, 5, 6, 7, 10, 11, 12, 15};

    iexr_unit #(.NUM_TYPES(16)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .exc_pending(exc_pending), .exc_info(info),
        .pipe_quiesced(pipe_quiesced), .ret_req(ret_req),
        .ret_kind(ret_kind), .exc_ack(exc_ack), .ret_ack(ret_ack),
        .redirect(redirect), .msw_out(msw_out),
        .sys_reset_req(sys_reset_req));
    iexr_pipe_model #(.N(16)) u_pipe (.hclk(hclk), .hresetn(hresetn),
        .raise(raise), .exc_ack(exc_ack), .exc_pending(exc_pending),
        .pipe_quiesced(pipe_quiesced));

    initial forever #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (sys_reset_req === 1'b1) nrst++;
        if (cyc == 20000) begin
            fails++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(rd, exp);
    endtask : rdc

    task automatic take(input int t);
        int c;
        c = (t == 1) ? 2 : (t == 0 || t == 12 || t == 15) ? 1 : 0;
        do @(posedge hclk); while (exc_ack === '0);
        chk({16'h0, exc_ack}, 32'h1 << t);
        chk({31'h0, redirect.valid}, 32'h1);
        chk(redirect.addr, {vpfx[31:16], vofs[t][15:4], 4'h0});
        sa[c] = (t == 0 || t == 4 || t == 10 || t == 11 || t == 12)
            ? info[t].next_addr : info[t].forced ? info[t].forced_addr
            : info[t].sel_next ? info[t].next_addr : info[t].fault_addr;
        ss[c] = msw;
        msw = msw & ~(ALL | (c == 1 ? CR : '0) | (c == 2 ? MC : '0));
        chk(msw_out, msw);
        if (c == 2) mcsyn = info[t].syndrome;
        else if (info[t].syn_valid) esyn = info[t].syndrome;
    endtask : take

    task automatic regs(input int c);
        rdc(4 + 8 * c, sa[c]);
        rdc(8 + 8 * c, ss[c]);
        rdc(`IEXR_OFS_ESYN, esyn);
        rdc(`IEXR_OFS_MCSYN, mcsyn);
    endtask : regs

    task automatic ret(input int c);
        @(posedge hclk);
        ret_kind <= iexr_ret_e'(c);
        ret_req  <= 1'b1;
        do @(posedge hclk); while (ret_ack !== 1'b1);
        ret_req <= 1'b0;
        chk(redirect.addr, sa[c]);
        chk(msw_out, ss[c]);
        msw = ss[c];
    endtask : ret

    task automatic finish_test();
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        for (int i = 0; i < 16; i++) info[i] = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 44; a += 4) rdc(a, '0);
        vpfx = $random(seed) & 32'hffff_0000;
        bus(1'b1, `IEXR_OFS_VPREFIX, vpfx);
        rdc(`IEXR_OFS_VPREFIX, vpfx);
        for (int i = 0; i < 16; i++) begin
            vofs[i] = $random(seed) & 32'h0000_fff0;
            bus(1'b1, 32'h40 + 4 * i, vofs[i]);
        end
        foreach (tl[k]) begin
            t = tl[k];
            e = {$random(seed), $random(seed), $random(seed),
                 4'($random(seed)), $random(seed)};
            e.imprecise = (t == 5 || t == 7);
            e.forced = (t == 7);
            if (e.imprecise) e.sel_next = 1'b0;
            info[t] <= e;
            bus(1'b1, `IEXR_OFS_MSW, DEF);
            msw = DEF;
            raise <= 16'h1 << t;
            @(posedge hclk);
            raise <= '0;
            take(t);
            regs(t == 1 ? 2 : (t == 0 || t == 12 || t == 15) ? 1 : 0);
            ret(t == 1 ? 2 : (t == 0 || t == 12 || t == 15) ? 1 : 0);
        end
        // critical first, then noncritical; external stays masked
        bus(1'b1, `IEXR_OFS_MSW, DEF);
        msw = DEF;
        raise <= 16'h0051;
        @(posedge hclk);
        raise <= '0;
        take(0);
        take(6);
        regs(1);
        regs(0);
        chk({31'h0, exc_pending[4]}, 32'h1);
        ret(0);
        ret(1);
        take(4);
        regs(0);
        ret(0);
        bus(1'b1, `IEXR_OFS_MSW, DEF & ~(32'h1 << `IEXR_MSW_DE));
        bus(1'b1, `IEXR_OFS_DBGCTL, 32'h1 << `IEXR_DBG_RST_BIT);
        chk(nrst, 0);
        bus(1'b1, `IEXR_OFS_MSW, DEF);
        bus(1'b1, `IEXR_OFS_DBGCTL, 32'h1 << `IEXR_DBG_RST_BIT);
        repeat (2) @(posedge hclk);
        chk(nrst, 1);
        rdc(`IEXR_OFS_DBGCTL, '0);
        bus(1'b1, 32'h80, $random(seed));
        rdc(32'h80, '0);
        // far side answers the request with a mid-run core reset
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(msw_out, `IEXR_MSW_RESET);
        hresetn <= 1'b1;
        rdc(`IEXR_OFS_MSW, `IEXR_MSW_RESET);
        chk(nrst, 1);
        finish_test();
    end
endmodule : tb_interrupt_entry_return
`default_nettype wire
